// ---- pkg/sbtc_pkg.sv ----
// Purpose: Shared constants for the sixteen-bit timer/counter.
// Assumes: Byte-wide register port with 8-bit addresses.
// Notes: Offsets are byte addresses on the plain register port.
package sbtc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int PS_W = 3;

    localparam logic [7:0] ADDR_FLAG = 8'h0c;
    localparam logic [7:0] ADDR_CNT_LO = 8'h0e;
    localparam logic [7:0] ADDR_CNT_HI = 8'h0f;
    localparam logic [7:0] ADDR_CTRL = 8'h10;
    localparam logic [7:0] ADDR_IEN = 8'h8c;

    localparam int CTRL_ON = 0;
    localparam int CTRL_SRC = 1;
    localparam int CTRL_NOSYNC = 2;
    localparam int CTRL_OSCEN = 3;
    localparam int CTRL_PS_LO = 4;
    localparam int CTRL_W = 6;
    localparam int FLAG_OVF = 0;
    localparam int IEN_OVF = 0;

    localparam logic [5:0] CTRL_RESET = 6'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hffff;
    localparam logic [15:0] CNT_ONE = 16'h0001;
    localparam logic [1:0] PS_ONE_TO_ONE = 2'h0;

    // The instruction cycle is four oscillator periods; clk is the oscillator.
    localparam int PHASES_PER_INSTR = 4;
    localparam logic [1:0] PHASE_Q2 = 2'h1;
    localparam logic [1:0] PHASE_Q4 = 2'h3;
    localparam logic [1:0] PHASE_STEP = 2'h1;
    localparam logic [3:0] CMP_MODE_TRIGGER = 4'hb;
endpackage

// ---- rtl/sbtc_prescaler.sv ----
// Purpose: Input prescaler dividing the count clock by 1, 2, 4 or 8.
// Assumes: clk_level is already in the clk domain.
// Notes: Above 1:1 the output is a counter bit, so it is a symmetrical square wave; at 1:1 it is the input.
`timescale 1ns/1ps
`default_nettype none
module sbtc_prescaler #(
    parameter int PS_W = sbtc_pkg::PS_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic clk_level,
    input wire logic [1:0] sel,
    output logic div_out
);
    logic prev_ff;
    logic [PS_W-1:0] cnt_ff;
    logic rise;

    assign rise = clk_level && !prev_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_ff <= 1'b0;
        end
        else
        begin
            prev_ff <= clk_level;
        end
    end

    // Counts every rising input edge, also in sleep; writes to the count bytes clear it.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_ff <= '0;
        end
        else if (clr)
        begin
            cnt_ff <= '0;
        end
        else if (rise)
        begin
            cnt_ff <= cnt_ff + PS_W'(1);
        end
    end

    // At 1:1 the input itself is the output; otherwise a symmetrical counter bit.
    always_comb
    begin
        if (sel == sbtc_pkg::PS_ONE_TO_ONE)
        begin
            div_out = clk_level;
        end
        else
        begin
            div_out = cnt_ff[sel - 2'h1];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_ps_clear_write: assert property (clr |=> cnt_ff == '0)
        else $error("prescaler not cleared by count write");
    a_ps_counts_edge: assert property (rise && !clr |=> cnt_ff == $past(cnt_ff) + PS_W'(1))
        else $error("prescaler missed an input edge");
endmodule
`default_nettype wire

// ---- rtl/sbtc_timer.sv ----
// Purpose: Sixteen-bit timer/counter with timer, synchronized and asynchronous counter modes.
// Assumes: clk is the oscillator; pins are asynchronous and synchronized here.
// Notes: rst_n is power-on reset; soft_rst_n is any other reset.
//
// The address map and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sbtc_timer #(
    parameter int ADDR_W = sbtc_pkg::ADDR_W,
    parameter int DATA_W = sbtc_pkg::DATA_W
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_rst_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [DATA_W-1:0] rd_data,
    input wire logic sleep_mode,
    input wire logic ext_count_clock_pin,
    input wire logic crystal_in_pin,
    output logic crystal_out_pin,
    output logic crystal_out_oe,
    input wire logic [3:0] compare_unit_mode_field,
    input wire logic special_event_trig,
    output logic [15:0] count_value,
    output logic timebase_valid,
    output logic overflow_irq
);
    logic [sbtc_pkg::CTRL_W-1:0] ctrl_ff;
    logic [15:0] count_ff;
    logic overflow_flag_ff;
    logic overflow_irq_enable_ff;
    logic [DATA_W-1:0] rd_data_ff;
    logic [1:0] phase_ff;
    logic [1:0] ext_sync_ff;
    logic [1:0] xtal_sync_ff;
    logic samp_ff;
    logic tick_prev_ff;
    logic counter_on;
    logic count_source_select;
    logic external_sync_disable;
    logic crystal_osc_enable;
    logic [1:0] input_prescale_select;
    logic async_mode;
    logic inst_clk;
    logic src_level;
    logic div_out;
    logic tick_level;
    logic inc_pulse;
    logic wr_lo;
    logic wr_hi;
    logic cnt_wr;
    logic trig_take;
    logic wrap;
    logic nxt_overflow_flag;
    logic [DATA_W-1:0] nxt_rd_data;

    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] target);
        hit = (a == ADDR_W'(target));
    endfunction

    assign counter_on = ctrl_ff[sbtc_pkg::CTRL_ON];
    assign count_source_select = ctrl_ff[sbtc_pkg::CTRL_SRC];
    assign external_sync_disable = ctrl_ff[sbtc_pkg::CTRL_NOSYNC];
    assign crystal_osc_enable = ctrl_ff[sbtc_pkg::CTRL_OSCEN];
    assign input_prescale_select = ctrl_ff[sbtc_pkg::CTRL_PS_LO +: 2];
    // Sync disable only matters with an external source.
    assign async_mode = count_source_select && external_sync_disable;
    assign wr_lo = wr_en && hit(addr, sbtc_pkg::ADDR_CNT_LO);
    assign wr_hi = wr_en && hit(addr, sbtc_pkg::ADDR_CNT_HI);
    assign cnt_wr = wr_lo || wr_hi;
    assign count_value = count_ff;
    assign timebase_valid = !async_mode;
    assign overflow_irq = overflow_flag_ff && overflow_irq_enable_ff;

    // Crystal amplifier: drives the inverted input back out while enabled, sleep or not.
    assign crystal_out_pin = !xtal_sync_ff[1] && crystal_osc_enable;
    assign crystal_out_oe = crystal_osc_enable;

    // The trigger clear is honoured only while the count is synchronous to clk.
    assign trig_take = special_event_trig && !async_mode
        && (compare_unit_mode_field == sbtc_pkg::CMP_MODE_TRIGGER);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ext_sync_ff <= 2'b00;
            xtal_sync_ff <= 2'b00;
        end
        else
        begin
            ext_sync_ff <= {ext_sync_ff[0], ext_count_clock_pin};
            xtal_sync_ff <= {xtal_sync_ff[0], crystal_in_pin};
        end
    end

    // Instruction clock phases; they stop in sleep like the core clock.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            phase_ff <= 2'b00;
        end
        else if (!sleep_mode)
        begin
            phase_ff <= phase_ff + sbtc_pkg::PHASE_STEP;
        end
    end

    // High in Q3 and Q4, giving one rising edge per instruction cycle.
    assign inst_clk = phase_ff[1];

    always_comb
    begin
        if (!count_source_select)
        begin
            src_level = inst_clk;
        end
        else if (crystal_osc_enable)
        begin
            src_level = xtal_sync_ff[1];
        end
        else
        begin
            src_level = ext_sync_ff[1];
        end
    end

    sbtc_prescaler #(
        .PS_W(sbtc_pkg::PS_W)
    ) u_prescaler (
        .clk(clk),
        .rst_n(rst_n),
        .clr(cnt_wr),
        .clk_level(src_level),
        .sel(input_prescale_select),
        .div_out(div_out)
    );

    // Samples the prescaler output on Q2 and Q4; no sampling while asleep.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            samp_ff <= 1'b0;
        end
        else if (!sleep_mode && (phase_ff == sbtc_pkg::PHASE_Q2 || phase_ff == sbtc_pkg::PHASE_Q4))
        begin
            samp_ff <= div_out;
        end
    end

    // Asynchronous mode bypasses the phase sampler and keeps counting in sleep.
    assign tick_level = async_mode ? div_out : samp_ff;
    assign inc_pulse = counter_on && tick_level && !tick_prev_ff;
    assign wrap = inc_pulse && (count_ff == sbtc_pkg::CNT_MAX) && !trig_take && !cnt_wr;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_prev_ff <= 1'b0;
        end
        else
        begin
            tick_prev_ff <= tick_level;
        end
    end

    // A write beats the trigger, the trigger beats counting; stopped means hold.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count_ff <= sbtc_pkg::CNT_ZERO;
        end
        else if (cnt_wr)
        begin
            if (wr_lo)
            begin
                count_ff[7:0] <= wr_data;
            end
            if (wr_hi)
            begin
                count_ff[15:8] <= wr_data;
            end
        end
        else if (trig_take)
        begin
            count_ff <= sbtc_pkg::CNT_ZERO;
        end
        else if (inc_pulse)
        begin
            count_ff <= count_ff + sbtc_pkg::CNT_ONE;
        end
    end

    // A real wrap or a written 1 sets the flag; a wrap wins over a software clear.
    assign nxt_overflow_flag = wrap
        || ((wr_en && hit(addr, sbtc_pkg::ADDR_FLAG)) ? wr_data[sbtc_pkg::FLAG_OVF] : overflow_flag_ff);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            overflow_flag_ff <= 1'b0;
            overflow_irq_enable_ff <= 1'b0;
        end
        else if (!soft_rst_n)
        begin
            overflow_flag_ff <= 1'b0;
            overflow_irq_enable_ff <= 1'b0;
        end
        else
        begin
            overflow_flag_ff <= nxt_overflow_flag;
            if (wr_en && hit(addr, sbtc_pkg::ADDR_IEN))
            begin
                overflow_irq_enable_ff <= wr_data[sbtc_pkg::IEN_OVF];
            end
        end
    end

    // Control survives every reset except power-on.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_ff <= sbtc_pkg::CTRL_RESET;
        end
        else if (wr_en && hit(addr, sbtc_pkg::ADDR_CTRL))
        begin
            ctrl_ff <= wr_data[sbtc_pkg::CTRL_W-1:0];
        end
    end

    // Count bytes are clk-domain flops, so a read never sees a half-updated value.
    always_comb
    begin
        nxt_rd_data = sbtc_pkg::BYTE_ZERO;
        if (rd_en)
        begin
            if (hit(addr, sbtc_pkg::ADDR_CNT_LO))
            begin
                nxt_rd_data = count_ff[7:0];
            end
            else if (hit(addr, sbtc_pkg::ADDR_CNT_HI))
            begin
                nxt_rd_data = count_ff[15:8];
            end
            else if (hit(addr, sbtc_pkg::ADDR_CTRL))
            begin
                nxt_rd_data = DATA_W'(ctrl_ff);
            end
            else if (hit(addr, sbtc_pkg::ADDR_FLAG))
            begin
                nxt_rd_data = DATA_W'(overflow_flag_ff);
            end
            else if (hit(addr, sbtc_pkg::ADDR_IEN))
            begin
                nxt_rd_data = DATA_W'(overflow_irq_enable_ff);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_data_ff <= sbtc_pkg::BYTE_ZERO;
        end
        else
        begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    assign rd_data = rd_data_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_timer_idle3;
        !inc_pulse [*3];
    endsequence

    a_off_holds_count: assert property (!counter_on && !cnt_wr && !trig_take |=> $stable(count_ff))
        else $error("count moved while stopped");
    a_wrap_sets_flag: assert property (wrap |=> count_ff == sbtc_pkg::CNT_ZERO && overflow_flag_ff)
        else $error("wrap did not clear count and set flag");
    a_trig_no_flag: assert property (trig_take && !overflow_flag_ff && !wr_en |=> !overflow_flag_ff)
        else $error("trigger clear set the overflow flag");
    a_trig_clears_count: assert property (trig_take && !cnt_wr |=> count_ff == sbtc_pkg::CNT_ZERO)
        else $error("trigger did not clear count");
    a_write_beats_trig: assert property (wr_lo && trig_take |=> count_ff[7:0] == $past(wr_data))
        else $error("write lost against trigger");
    a_sleep_sync_stall: assert property (sleep_mode && $past(sleep_mode) && !async_mode |-> !inc_pulse)
        else $error("synchronous count advanced in sleep");
    a_timer_one_per_instr: assert property (inc_pulse && !count_source_select && !sleep_mode
        && input_prescale_select == sbtc_pkg::PS_ONE_TO_ONE && !wr_en |=> s_timer_idle3)
        else $error("timer counted faster than the instruction clock");
    a_async_no_timebase: assert property (async_mode |-> !timebase_valid)
        else $error("async count offered as timebase");
    a_ctrl_keeps_soft: assert property (!soft_rst_n && !wr_en |=> $stable(ctrl_ff))
        else $error("control changed on non power-on reset");
    a_irq_gated: assert property (overflow_irq == (overflow_flag_ff && overflow_irq_enable_ff))
        else $error("interrupt not gated by enable");
    a_read_next_cycle: assert property (rd_en && hit(addr, sbtc_pkg::ADDR_CNT_HI) && !cnt_wr
        |=> rd_data == $past(count_ff[15:8]))
        else $error("high byte read wrong");
endmodule
`default_nettype wire

// ---- verification/sbtc_clk_src.sv ----
// Purpose: Model of the external count clock source and of the crystal on its input pin.
// Assumes: Pulses are timed in oscillator cycles, HALF cycles high and HALF cycles low.
// Notes: Both pins stand still low between bursts, as a gated clock source would.
`timescale 1ns/1ps
`default_nettype none
module sbtc_clk_src #(
    parameter int HALF = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [7:0] n_edges,
    input wire logic xtal_sel,
    output logic ext_pin,
    output logic xtal_pin,
    output logic busy
);
    logic [7:0] left_ff;
    logic [7:0] tick_ff;
    logic lvl_ff;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            left_ff <= 8'h00;
            tick_ff <= 8'h00;
            lvl_ff <= 1'b0;
        end
        else if (start)
        begin
            left_ff <= n_edges;
            tick_ff <= 8'h00;
        end
        else if (left_ff != 8'h00)
        begin
            if (tick_ff == 8'(HALF - 1))
            begin
                tick_ff <= 8'h00;
                lvl_ff <= ~lvl_ff;
                if (lvl_ff)
                    left_ff <= left_ff - 8'h01;
            end
            else
                tick_ff <= tick_ff + 8'h01;
        end
    end

    assign ext_pin = ~xtal_sel & lvl_ff;
    assign xtal_pin = xtal_sel & lvl_ff;
    assign busy = (left_ff != 8'h00);
endmodule
`default_nettype wire

// ---- verification/sixteen_bit_timer_counter_bench.sv ----
// Purpose: Self-checking bench for the sixteen-bit timer/counter.
// Assumes: Counter byte writes are made with the counter stopped.
// Notes: Count deltas are taken from the count_value port between two sample points.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module sixteen_bit_timer_counter_bench;
    logic clk, rst_n, soft_rst_n, wr_en, rd_en, sleep_mode, trig, start, xtal_sel;
    logic [7:0] addr, wr_data, rd_data, n_edges, r;
    logic [3:0] cmp_mode;
    logic [15:0] count_value, c0;
    logic ext_pin, xtal_pin, busy, xo, xoe, tbv, irq;
    int n_fail, total_checks;

    sbtc_timer DUT (.clk(clk), .rst_n(rst_n), .soft_rst_n(soft_rst_n), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .sleep_mode(sleep_mode),
        .ext_count_clock_pin(ext_pin), .crystal_in_pin(xtal_pin), .crystal_out_pin(xo),
        .crystal_out_oe(xoe), .compare_unit_mode_field(cmp_mode), .special_event_trig(trig),
        .count_value(count_value), .timebase_valid(tbv), .overflow_irq(irq));
    sbtc_clk_src src (.clk(clk), .rst_n(rst_n), .start(start), .n_edges(n_edges), .xtal_sel(xtal_sel),
        .ext_pin(ext_pin), .xtal_pin(xtal_pin), .busy(busy));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        r = rd_data;
    endtask
    task automatic set_cnt(input logic [15:0] v);
        wr(sbtc_pkg::ADDR_CTRL, 8'h00);
        wr(sbtc_pkg::ADDR_CNT_HI, v[15:8]);
        wr(sbtc_pkg::ADDR_CNT_LO, v[7:0]);
    endtask
    // Selects the source with the counter stopped and clears the prescaler, so no stale level counts as an edge.
    task automatic ext_on(input logic [7:0] ctl);
        wr(sbtc_pkg::ADDR_CTRL, ctl & 8'hfe);
        wr(sbtc_pkg::ADDR_CNT_LO, 8'h00);
        wr(sbtc_pkg::ADDR_CTRL, ctl);
    endtask
    task automatic send(input logic [7:0] n, input logic xs);
        int i;
        @(posedge clk);
        start <= 1'b1;
        n_edges <= n;
        xtal_sel <= xs;
        @(posedge clk);
        start <= 1'b0;
        #1;
        i = 0;
        while (busy && i < 5000)
        begin
            @(posedge clk);
            i++;
        end
        `CHK(busy, 1'b0)
        tk(12);
    endtask
    task automatic ptrig();
        @(posedge clk);
        trig <= 1'b1;
        @(posedge clk);
        trig <= 1'b0;
        #1;
    endtask
    task automatic rate(input logic [7:0] ctl, input int n, input logic [15:0] exp);
        wr(sbtc_pkg::ADDR_CTRL, ctl);
        tk(9);
        c0 = count_value;
        tk(n);
        `CHK(count_value - c0, exp)
    endtask

    task automatic t_reset();
        rd(sbtc_pkg::ADDR_CTRL);
        `CHK(r, 8'h00)
        `CHK(tbv, 1'b1)
        `CHK(xoe, 1'b0)
        `CHK(xo, 1'b0)
        `CHK(count_value, 16'h0000)
        rd(8'h20);
        `CHK(r, 8'h00)
    endtask
    task automatic t_timer();
        set_cnt(16'h0000);
        rate(8'h01, 40, 16'h000a);
        rate(8'h05, 40, 16'h000a);
        rate(8'h31, 64, 16'h0002);
        rate(8'h21, 64, 16'h0004);
        wr(sbtc_pkg::ADDR_CTRL, 8'h00);
        #1;
        c0 = count_value;
        tk(20);
        `CHK(count_value, c0)
        set_cnt(16'h12f4);
        rd(sbtc_pkg::ADDR_CNT_HI);
        `CHK(r, 8'h12)
        rd(sbtc_pkg::ADDR_CNT_LO);
        `CHK(r, 8'hf4)
        rd(sbtc_pkg::ADDR_CNT_HI);
        `CHK(r, 8'h12)
    endtask
    task automatic t_ext();
        set_cnt(16'h0000);
        ext_on(8'h03);
        send(8'h05, 1'b0);
        `CHK(count_value, 16'h0005)
        wr(sbtc_pkg::ADDR_CTRL, 8'h0b);
        // The crystal is given time to start before its edges are relied on.
        tk(20);
        send(8'h05, 1'b1);
        `CHK(count_value, 16'h000a)
        `CHK(xoe, 1'b1)
        `CHK(xo, 1'b1)
        set_cnt(16'h0000);
        ext_on(8'h13);
        send(8'h07, 1'b0);
        `CHK(count_value, 16'h0004)
        set_cnt(16'h0000);
        ext_on(8'h13);
        send(8'h01, 1'b0);
        `CHK(count_value, 16'h0001)
    endtask
    task automatic t_sleep();
        set_cnt(16'h0000);
        ext_on(8'h03);
        sleep_mode <= 1'b1;
        send(8'h04, 1'b0);
        `CHK(count_value, 16'h0000)
        wr(sbtc_pkg::ADDR_CTRL, 8'h07);
        send(8'h04, 1'b0);
        `CHK(count_value, 16'h0004)
        `CHK(tbv, 1'b0)
        @(posedge clk);
        cmp_mode <= sbtc_pkg::CMP_MODE_TRIGGER;
        ptrig();
        `CHK(count_value, 16'h0004)
        @(posedge clk);
        sleep_mode <= 1'b0;
        rd(sbtc_pkg::ADDR_CNT_LO);
        `CHK(r, 8'h04)
    endtask
    task automatic t_trig();
        set_cnt(16'h4000);
        cmp_mode <= 4'h3;
        ptrig();
        `CHK(count_value, 16'h4000)
        @(posedge clk);
        cmp_mode <= sbtc_pkg::CMP_MODE_TRIGGER;
        addr <= sbtc_pkg::ADDR_CNT_LO;
        wr_data <= 8'h55;
        wr_en <= 1'b1;
        trig <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
        trig <= 1'b0;
        #1;
        `CHK(count_value[7:0], 8'h55)
        wr(sbtc_pkg::ADDR_CTRL, 8'h01);
        tk(10);
        ptrig();
        `CHK(count_value, 16'h0000)
        rd(sbtc_pkg::ADDR_FLAG);
        `CHK(r[0], 1'b0)
    endtask
    task automatic t_ovf();
        set_cnt(16'hfffe);
        wr(sbtc_pkg::ADDR_IEN, 8'h01);
        wr(sbtc_pkg::ADDR_CTRL, 8'h01);
        tk(20);
        `CHK(count_value[15:8], 8'h00)
        `CHK(irq, 1'b1)
        rd(sbtc_pkg::ADDR_FLAG);
        `CHK(r[0], 1'b1)
        @(posedge clk);
        soft_rst_n <= 1'b0;
        @(posedge clk);
        soft_rst_n <= 1'b1;
        tk(1);
        `CHK(irq, 1'b0)
        rd(sbtc_pkg::ADDR_CTRL);
        `CHK(r, 8'h01)
    endtask

    task automatic test_done();
        $display("checks %0d, mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        #200000;
        n_fail++;
        test_done();
    end

    initial
    begin
        n_fail = 0;
        total_checks = 0;
        rst_n = 1'b0;
        soft_rst_n = 1'b1;
        addr = 8'h00;
        wr_data = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        sleep_mode = 1'b0;
        trig = 1'b0;
        cmp_mode = 4'h0;
        start = 1'b0;
        n_edges = 8'h00;
        xtal_sel = 1'b0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_timer();
        t_ext();
        t_sleep();
        t_trig();
        t_ovf();
        test_done();
    end
endmodule
`default_nettype wire
